// ===== logic/timer8.v
// 8-bit capture/compare timer with one-pulse and pwm modes, apb register slave
//
// Overview of operation
// - capture irq enable lets either capture flag raise the timer interrupt
// - compare irq enable lets either match flag raise the timer interrupt
// - overflow irq enable lets the overflow flag raise the timer interrupt
// - writing force_out_two as 1 copies level two onto pin two if enabled
// - writing force_out_one as 1 copies level one onto pin one if enabled
// - compare-2 match drives level two onto pin two outside pulse/pwm modes; onto pin one in pwm mode
// - capture_edge_one picks falling (0) or rising (1) edge on capture pin one
// - compare-1 match drives level one onto pin one when enabled
// - pin enables route the output and gate its level changes; matching and flags run regardless
// - single-pulse mode: capture pin one edge starts one pulse sized by compare one
// - pwm mode: pin one cycles, pulse by compare one, period by compare two
// - clock select: 00 div 4, 01 div 2, 10 div 8, 11 slow div 8000
// - capture_edge_two picks falling (0) or rising (1) edge on capture pin two
// - capture flag one sets on capture or pwm period end; cleared by flags read then access
// - match flag one sets on compare-1 match; cleared by flags read then access
// - overflow flag sets on ff to 00; cleared via count, not alternate count
// - capture flag two sets on capture two; cleared by flags read then access
// - match flag two sets on compare-2 match; cleared by flags read then access
// - freeze bit stops prescaler, counter and outputs; registers stay accessible
// - capture registers hold the counter value at their capture event
// - compare registers are read/write, reset 00, compared continuously
// - writing either counter register resets count to fc; reads return count
// - in pwm mode compare values take effect only at the period end
// - in pwm mode the compare-2 event reloads the counter with fc
// - in pwm mode hardware never sets the match flags
// - pwm and single-pulse both set means pwm mode only
`timescale 1ns/100ps
`include "timer8_defines.vh"

module timer8 #(
  parameter SLOW_DIV = `DIV_SLOW
) (
  // clock and reset
  input  wire        clock,
  input  wire        rstn,
  // apb slave
  input  wire [11:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // capture inputs
  input  wire        capture_pin_one,
  input  wire        capture_pin_two,
  // compare outputs, enable high while the timer owns the pin
  output reg         compare_pin_one,
  output reg         compare_pin_one_en,
  output reg         compare_pin_two,
  output reg         compare_pin_two_en,
  // timer interrupt request
  output reg         timer_irq
);

  // is the apb address the word of register index idx
  function hit_idx;
    input [11:0] addr;
    input [7:0]  idx;
    begin
      hit_idx = (addr[11:10] == 2'b00) && (addr[9:2] == idx);
    end
  endfunction

  // prescaler limit (divisor minus one) for a clock select code
  function [12:0] presc_limit;
    input [1:0] sel;
    begin
      case (sel)
        2'b00:   presc_limit = 13'd`DIV_SEL_00 - 13'd1;
        2'b01:   presc_limit = 13'd`DIV_SEL_01 - 13'd1;
        2'b10:   presc_limit = 13'd`DIV_SEL_10 - 13'd1;
        default: presc_limit = SLOW_DIV[12:0] - 13'd1;
      endcase
    end
  endfunction

  // state
  reg  [7:0]  ctrl_a_q;
  reg  [7:0]  ctrl_b_q;
  reg  [4:0]  flags_q;
  reg  [4:0]  flags_d;
  reg  [4:0]  arm_q;
  reg  [4:0]  arm_d;
  reg         freeze_q;
  reg  [7:0]  count_q;
  reg  [7:0]  count_d;
  reg  [12:0] presc_q;
  reg  [12:0] presc_d;
  reg  [7:0]  cap_one_q;
  reg  [7:0]  cap_two_q;
  reg  [7:0]  cmp_one_q;
  reg  [7:0]  cmp_two_q;
  reg  [7:0]  cmp_one_act_q;
  reg  [7:0]  cmp_two_act_q;
  reg  [1:0]  cap_prev_q;
  reg         pin_one_d;
  reg         pin_two_d;
  reg  [7:0]  rd_mux;

  // apb phases
  wire        setup    = psel & ~penable;
  wire        done     = psel & penable & pready;
  wire        wr_done  = done & pwrite;
  wire        rd_done  = done & ~pwrite;
  wire [7:0]  wbyte    = pwdata[7:0];

  wire        wr_ctrl_a = wr_done & hit_idx(paddr, `IDX_CONTROL_A);
  wire        wr_ctrl_b = wr_done & hit_idx(paddr, `IDX_CONTROL_B);
  wire        wr_flags  = wr_done & hit_idx(paddr, `IDX_FLAGS);
  wire        rd_flags  = rd_done & hit_idx(paddr, `IDX_FLAGS);
  wire        wr_cmp1   = wr_done & hit_idx(paddr, `IDX_COMPARE_ONE);
  wire        wr_cmp2   = wr_done & hit_idx(paddr, `IDX_COMPARE_TWO);
  wire        wr_count  = wr_done & (hit_idx(paddr, `IDX_COUNT) |
                                     hit_idx(paddr, `IDX_COUNT_ALT));
  wire        valid_idx = hit_idx(paddr, `IDX_CONTROL_B) | hit_idx(paddr, `IDX_CONTROL_A) |
                          hit_idx(paddr, `IDX_FLAGS) | hit_idx(paddr, `IDX_CAPTURE_ONE) |
                          hit_idx(paddr, `IDX_COMPARE_ONE) | hit_idx(paddr, `IDX_COUNT) |
                          hit_idx(paddr, `IDX_COUNT_ALT) | hit_idx(paddr, `IDX_CAPTURE_TWO) |
                          hit_idx(paddr, `IDX_COMPARE_TWO);

  // any access (read or write) that completes the clear sequence of each flag,
  // ordered like flags_q: capture one, match one, overflow, capture two, match two
  wire [4:0]  flag_acc = {5{done}} & {hit_idx(paddr, `IDX_CAPTURE_ONE),
                                      hit_idx(paddr, `IDX_COMPARE_ONE),
                                      hit_idx(paddr, `IDX_COUNT),
                                      hit_idx(paddr, `IDX_CAPTURE_TWO),
                                      hit_idx(paddr, `IDX_COMPARE_TWO)};

  // modes
  wire        pwm_mode    = ctrl_b_q[`CB_PWM];
  wire        pulse_mode  = ctrl_b_q[`CB_SINGLE_PULSE] & ~pwm_mode;
  wire        pin_one_en  = ctrl_b_q[`CB_OUT_PIN_ONE_EN];
  wire        pin_two_en  = ctrl_b_q[`CB_OUT_PIN_TWO_EN];

  // prescaler tick; >= keeps a smaller divisor safe when the select changes mid-count
  wire [12:0] limit = presc_limit(ctrl_b_q[`CB_CLK_SEL_HI:`CB_CLK_SEL_LO]);
  wire        tick  = ~freeze_q & (presc_q >= limit);

  // compare events are judged on the count value that a tick is leaving
  wire        evt_one  = tick & (count_q == cmp_one_act_q);
  wire        evt_two  = tick & (count_q == cmp_two_act_q);
  wire        overflow = tick & (count_q == `COUNT_TOP) & ~(pwm_mode & evt_two);

  // capture edge detection, one channel per pin
  wire [1:0]  cap_pins  = {capture_pin_two, capture_pin_one};
  wire [1:0]  cap_edges = {ctrl_b_q[`CB_CAPTURE_EDGE_2], ctrl_a_q[`CA_CAPTURE_EDGE_1]};
  wire [1:0]  cap_seen;
  genvar      g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : cap_chan
      assign cap_seen[g] = cap_edges[g] ? (cap_pins[g] & ~cap_prev_q[g])
                                        : (~cap_pins[g] & cap_prev_q[g]);
    end
  endgenerate

  // capture pin one is cut off from the timer in pwm mode
  wire        cap_evt_one  = cap_seen[0] & ~pwm_mode;
  wire        cap_evt_two  = cap_seen[1];
  wire        pulse_start  = pulse_mode & cap_evt_one;

  // hardware flag sets, same order as flags_q
  wire [4:0]  flag_set = {cap_evt_one | (pwm_mode & evt_two),
                          evt_one & ~pwm_mode,
                          overflow,
                          cap_evt_two,
                          evt_two & ~pwm_mode};

  // flags: a set in the same cycle as its clear wins
  always @* begin
    flags_d = flag_set | (flags_q & ~(arm_q & flag_acc));
    // only flags seen as 1 by the status read are armed, so a later event survives
    if (rd_flags) begin
      arm_d = prdata[`FL_EVENT_HI:`FL_EVENT_LO];
    end else begin
      arm_d = arm_q & ~flag_acc;
    end
  end

  // prescaler and counter
  always @* begin
    presc_d = presc_q;
    count_d = count_q;
    if (wr_count | pulse_start) begin
      presc_d = 13'd0;
    end else if (tick) begin
      presc_d = 13'd0;
    end else if (~freeze_q) begin
      presc_d = presc_q + 13'd1;
    end
    if (wr_count) begin
      count_d = `RST_COUNT;
    end else if (pulse_start) begin
      count_d = `RST_COUNT;
    end else if (pwm_mode & evt_two) begin
      count_d = `RST_COUNT;
    end else if (tick) begin
      count_d = count_q + 8'd1;
    end
  end

  // compare pin levels; levels only move while the pin is routed to the timer
  // and not frozen, so a force while frozen cannot glitch an unowned pin
  always @* begin
    pin_one_d = compare_pin_one;
    pin_two_d = compare_pin_two;
    if (pin_one_en & ~freeze_q) begin
      if (pwm_mode) begin
        if (evt_two) begin
          pin_one_d = ctrl_a_q[`CA_OUT_LEVEL_TWO];
        end else if (evt_one) begin
          pin_one_d = ctrl_a_q[`CA_OUT_LEVEL_ONE];
        end
      end else if (pulse_start) begin
        pin_one_d = ctrl_a_q[`CA_OUT_LEVEL_TWO];
      end else if (evt_one) begin
        pin_one_d = ctrl_a_q[`CA_OUT_LEVEL_ONE];
      end
      if (wr_ctrl_a & wbyte[`CA_FORCE_OUT_ONE]) begin
        pin_one_d = wbyte[`CA_OUT_LEVEL_ONE];
      end
    end
    if (pin_two_en & ~freeze_q) begin
      if (evt_two & ~pwm_mode & ~pulse_mode) begin
        pin_two_d = ctrl_a_q[`CA_OUT_LEVEL_TWO];
      end
      if (wr_ctrl_a & wbyte[`CA_FORCE_OUT_TWO]) begin
        pin_two_d = wbyte[`CA_OUT_LEVEL_TWO];
      end
    end
  end

  // read data, sampled in the setup cycle
  always @* begin
    rd_mux = 8'h00;
    if (hit_idx(paddr, `IDX_CONTROL_B)) begin
      rd_mux = ctrl_b_q & `CB_WRITE_MASK;
    end else if (hit_idx(paddr, `IDX_CONTROL_A)) begin
      rd_mux = ctrl_a_q;
    end else if (hit_idx(paddr, `IDX_FLAGS)) begin
      rd_mux = {flags_q, freeze_q, 2'b00};
    end else if (hit_idx(paddr, `IDX_CAPTURE_ONE)) begin
      rd_mux = cap_one_q;
    end else if (hit_idx(paddr, `IDX_COMPARE_ONE)) begin
      rd_mux = cmp_one_q;
    end else if (hit_idx(paddr, `IDX_COUNT) | hit_idx(paddr, `IDX_COUNT_ALT)) begin
      rd_mux = count_q;
    end else if (hit_idx(paddr, `IDX_CAPTURE_TWO)) begin
      rd_mux = cap_two_q;
    end else if (hit_idx(paddr, `IDX_COMPARE_TWO)) begin
      rd_mux = cmp_two_q;
    end
  end

  // apb answer: no wait state, data and error registered at setup
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= {24'h00_0000, rd_mux};
      pready  <= 1'b1;
      pslverr <= ~valid_idx;
    end else if (done) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // software-written registers
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_a_q  <= `RST_CONTROL;
      ctrl_b_q  <= `RST_CONTROL;
      freeze_q  <= 1'b0;
      cmp_one_q <= `RST_COMPARE;
      cmp_two_q <= `RST_COMPARE;
    end else begin
      if (wr_ctrl_a) begin
        ctrl_a_q <= wbyte;
      end
      if (wr_ctrl_b) begin
        ctrl_b_q <= wbyte & `CB_WRITE_MASK;
      end
      if (wr_flags) begin
        freeze_q <= wbyte[`FL_FREEZE];
      end
      if (wr_cmp1) begin
        cmp_one_q <= wbyte;
      end
      if (wr_cmp2) begin
        cmp_two_q <= wbyte;
      end
    end
  end

  // working compare values: live outside pwm, reloaded at the period end in pwm
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cmp_one_act_q <= `RST_COMPARE;
      cmp_two_act_q <= `RST_COMPARE;
    end else if (~pwm_mode | evt_two) begin
      cmp_one_act_q <= cmp_one_q;
      cmp_two_act_q <= cmp_two_q;
    end
  end

  // timer state
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      flags_q    <= 5'b0_0000;
      arm_q      <= 5'b0_0000;
      count_q    <= `RST_COUNT;
      presc_q    <= 13'd0;
      cap_prev_q <= 2'b00;
      cap_one_q  <= 8'h00;
      cap_two_q  <= 8'h00;
    end else begin
      flags_q    <= flags_d;
      arm_q      <= arm_d;
      count_q    <= count_d;
      presc_q    <= presc_d;
      cap_prev_q <= cap_pins;
      if (cap_evt_one) begin
        cap_one_q <= count_q;
      end
      if (cap_evt_two) begin
        cap_two_q <= count_q;
      end
    end
  end

  // pins and interrupt; freeze takes the pins away from the timer
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      compare_pin_one    <= 1'b0;
      compare_pin_two    <= 1'b0;
      compare_pin_one_en <= 1'b0;
      compare_pin_two_en <= 1'b0;
      timer_irq          <= 1'b0;
    end else begin
      compare_pin_one    <= pin_one_d;
      compare_pin_two    <= pin_two_d;
      compare_pin_one_en <= pin_one_en & ~freeze_q;
      compare_pin_two_en <= pin_two_en & ~freeze_q;
      timer_irq          <= (ctrl_a_q[`CA_CAPTURE_IRQ_EN] & (flags_q[4] | flags_q[1])) |
                            (ctrl_a_q[`CA_COMPARE_IRQ_EN] & (flags_q[3] | flags_q[0])) |
                            (ctrl_a_q[`CA_OVERFLOW_IRQ_EN] & flags_q[2]);
    end
  end

endmodule

// ===== logic/timer8_defines.vh
// register map, field positions, reset values and prescaler figures of the 8-bit timer
`ifndef TIMER8_DEFINES_VH
`define TIMER8_DEFINES_VH

// register indices; the apb byte address is four times the index
`define IDX_CONTROL_B      8'h3c
`define IDX_CONTROL_A      8'h3d
`define IDX_FLAGS          8'h3e
`define IDX_CAPTURE_ONE    8'h3f
`define IDX_COMPARE_ONE    8'h40
`define IDX_COUNT          8'h41
`define IDX_COUNT_ALT      8'h42
`define IDX_CAPTURE_TWO    8'h43
`define IDX_COMPARE_TWO    8'h44

// timer_control_a fields
`define CA_CAPTURE_IRQ_EN  7
`define CA_COMPARE_IRQ_EN  6
`define CA_OVERFLOW_IRQ_EN 5
`define CA_FORCE_OUT_TWO   4
`define CA_FORCE_OUT_ONE   3
`define CA_OUT_LEVEL_TWO   2
`define CA_CAPTURE_EDGE_1  1
`define CA_OUT_LEVEL_ONE   0

// timer_control_b fields
`define CB_OUT_PIN_ONE_EN  7
`define CB_OUT_PIN_TWO_EN  6
`define CB_SINGLE_PULSE    5
`define CB_PWM             4
`define CB_CLK_SEL_HI      3
`define CB_CLK_SEL_LO      2
`define CB_CAPTURE_EDGE_2  1
`define CB_WRITE_MASK      8'hfe

// timer_flags fields; bits 7..3 hold the five event flags
`define FL_FREEZE          2
`define FL_EVENT_HI        7
`define FL_EVENT_LO        3

// reset values and the counter top value
`define RST_CONTROL        8'h00
`define RST_COMPARE        8'h00
`define RST_COUNT          8'hfc
`define COUNT_TOP          8'hff

// prescaler divisors for clock select 00, 01, 10, and the slow-clock divisor
`define DIV_SEL_00         4
`define DIV_SEL_01         2
`define DIV_SEL_10         8
`define DIV_SLOW           8000

`endif

// ===== verification/eight_bit_capture_compare_timer_tb.sv
// self-checking bench for the 8-bit capture/compare timer
`timescale 1ns/100ps
`include "timer8_defines.vh"
module eight_bit_capture_compare_timer_tb;
  // slow divisor shortened so the slow clock select stays quick
  localparam int SLOW = 16;
  logic        clock;
  logic        rstn;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  logic        capture_pin_one;
  logic        capture_pin_two;
  wire         compare_pin_one;
  wire         compare_pin_one_en;
  wire         compare_pin_two;
  wire         compare_pin_two_en;
  wire         timer_irq;
  int          miscompares;
  int          comparisons;
  int          hi;
  int          lo;
  logic [7:0]  rd;
  logic        err;
  int          divs [4] = '{4, 2, 8, SLOW};

  timer8 #(.SLOW_DIV(SLOW)) u_dut (
    .clock(clock), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_pin_one(capture_pin_one), .capture_pin_two(capture_pin_two),
    .compare_pin_one(compare_pin_one), .compare_pin_one_en(compare_pin_one_en),
    .compare_pin_two(compare_pin_two), .compare_pin_two_en(compare_pin_two_en),
    .timer_irq(timer_irq));

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one apb transfer; an edge passes after release so the next setup is clean
  task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h00_0000, wd};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    if (n == 20) cmp(8'h00, 8'h01, "apb answer missing");
    rd = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(idx, 1'b1, d);
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(idx, 1'b0, 8'h00);
    cmp(rd, exp, $sformatf("read of index %h", idx));
  endtask

  // prescaler phase leaves one tick of slack either way
  task automatic near(input logic [7:0] got, input logic [7:0] exp);
    logic [7:0] d;
    d = got - exp;
    cmp((d === 8'h01 || d === 8'hff) ? exp : got, exp, "count after timed run");
  endtask

  // bits: pin one enable, pin one, pin two enable, pin two, irq
  task automatic pins(input logic [4:0] exp);
    repeat (3) @(posedge clock);
    @(negedge clock);
    cmp({3'b000, compare_pin_one_en, compare_pin_one, compare_pin_two_en, compare_pin_two,
         timer_irq}, {3'b000, exp}, "pins and irq");
    @(posedge clock);
  endtask

  task automatic width(input logic lvl, output int w);
    w = 0;
    while (compare_pin_one !== lvl && w < 100) begin
      @(negedge clock);
      w++;
    end
    w = 0;
    while (compare_pin_one === lvl && w < 100) begin
      @(negedge clock);
      w++;
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial begin
    repeat (20000) @(posedge clock);
    cmp(8'h00, 8'h01, "watchdog expired");
    end_sim;
  end

  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    capture_pin_one = 1'b0;
    capture_pin_two = 1'b0;
    miscompares = 0;
    comparisons = 0;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    // freeze at once: a running counter would roll over and match before the flag checks
    rchk(`IDX_FLAGS, 8'h00);
    wr(`IDX_FLAGS, 8'hff);
    wr(`IDX_COUNT, 8'h00);
    rchk(`IDX_COUNT, `RST_COUNT);
    rchk(`IDX_CONTROL_A, `RST_CONTROL);
    rchk(`IDX_CONTROL_B, `RST_CONTROL);
    rchk(`IDX_COMPARE_ONE, `RST_COMPARE);
    rchk(`IDX_COMPARE_TWO, `RST_COMPARE);
    apb(8'h45, 1'b0, 8'h00);
    cmp({7'h00, err}, 8'h01, "unmapped error");
    rchk(`IDX_FLAGS, 8'h04);
    wr(`IDX_CONTROL_B, 8'h0f);
    rchk(`IDX_CONTROL_B, 8'h0e);
    wr(`IDX_COUNT, 8'h00);
    rchk(`IDX_COUNT, `RST_COUNT);
    repeat (20) @(posedge clock);
    rchk(`IDX_COUNT_ALT, `RST_COUNT);
    $display("test registers ended");
    for (int s = 0; s < 4; s++) begin
      wr(`IDX_CONTROL_B, 8'(s << 2));
      wr(`IDX_COUNT, 8'h00);
      wr(`IDX_FLAGS, 8'h00);
      repeat (32) @(posedge clock);
      wr(`IDX_FLAGS, 8'h04);
      apb(`IDX_COUNT, 1'b0, 8'h00);
      near(rd, 8'(`RST_COUNT + 35 / divs[s]));
    end
    rchk(`IDX_FLAGS, 8'h6c);
    pins(5'b00000);
    wr(`IDX_CONTROL_A, 8'h20);
    pins(5'b00001);
    apb(`IDX_COUNT_ALT, 1'b0, 8'h00);
    rchk(`IDX_FLAGS, 8'h6c);
    wr(`IDX_COUNT, 8'h00);
    rchk(`IDX_FLAGS, 8'h4c);
    pins(5'b00000);
    wr(`IDX_CONTROL_A, 8'h40);
    pins(5'b00001);
    apb(`IDX_COMPARE_ONE, 1'b0, 8'h00);
    wr(`IDX_COMPARE_TWO, 8'h00);
    rchk(`IDX_FLAGS, 8'h04);
    pins(5'b00000);
    $display("test clocks and flags ended");
    wr(`IDX_CONTROL_B, 8'h02);
    wr(`IDX_CONTROL_A, 8'h80);
    capture_pin_one <= 1'b1;
    repeat (3) @(posedge clock);
    rchk(`IDX_FLAGS, 8'h04);
    capture_pin_one <= 1'b0;
    repeat (3) @(posedge clock);
    rchk(`IDX_FLAGS, 8'h84);
    pins(5'b00001);
    rchk(`IDX_CAPTURE_ONE, `RST_COUNT);
    capture_pin_two <= 1'b1;
    repeat (3) @(posedge clock);
    rchk(`IDX_FLAGS, 8'h14);
    rchk(`IDX_CAPTURE_TWO, `RST_COUNT);
    capture_pin_two <= 1'b0;
    repeat (3) @(posedge clock);
    rchk(`IDX_FLAGS, 8'h04);
    pins(5'b00000);
    $display("test captures ended");
    wr(`IDX_FLAGS, 8'h00);
    wr(`IDX_CONTROL_B, 8'hc0);
    wr(`IDX_CONTROL_A, 8'h1d);
    pins(5'b11110);
    wr(`IDX_CONTROL_A, 8'h18);
    pins(5'b10100);
    $display("test forced outputs ended");
    wr(`IDX_FLAGS, 8'h04);
    apb(`IDX_FLAGS, 1'b0, 8'h00);
    wr(`IDX_COMPARE_ONE, 8'h00);
    wr(`IDX_COMPARE_TWO, 8'h04);
    wr(`IDX_CONTROL_A, 8'h04);
    wr(`IDX_CONTROL_B, 8'h94);
    wr(`IDX_COUNT, 8'h00);
    wr(`IDX_FLAGS, 8'h00);
    width(1'b1, hi);
    width(1'b0, lo);
    cmp(8'(hi), 8'h0a, "pwm high time");
    cmp(8'(lo), 8'h08, "pwm low time");
    @(posedge clock);
    wr(`IDX_COMPARE_ONE, 8'h01);
    width(1'b1, hi);
    width(1'b1, hi);
    cmp(8'(hi), 8'h0c, "pwm high after update");
    @(posedge clock);
    apb(`IDX_FLAGS, 1'b0, 8'h00);
    cmp(rd & 8'hdc, 8'h80, "pwm flags");
    $display("test pwm ended");
    wr(`IDX_CONTROL_B, 8'ha4);
    wr(`IDX_CONTROL_A, 8'h0e);
    capture_pin_one <= 1'b1;
    width(1'b1, hi);
    cmp(8'(hi), 8'h0c, "single pulse width");
    $display("test single pulse ended");
    end_sim;
  end
endmodule

// ===== verification/timer8_assertions.sv
// port-level assertions for the 8-bit capture/compare timer
`timescale 1ns/100ps
module timer8_checker (
  // clock and reset
  input wire        clock,
  input wire        rstn,
  // apb
  input wire [11:0] paddr,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // timer pins
  input wire        compare_pin_one,
  input wire        compare_pin_one_en,
  input wire        compare_pin_two_en,
  input wire        timer_irq
);
  reg  [7:0] ctl_a_q;
  reg  [7:0] ctl_b_q;
  reg        frz_q;
  wire       wr_done = psel && penable && pwrite && pready;
  wire       mapped = paddr[11:10] == 2'b00 && paddr[1:0] == 2'b00 &&
                      paddr[9:2] >= 8'h3c && paddr[9:2] <= 8'h44;

  // shadow of the control bits, updated only when a write completes
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctl_a_q <= 8'h00;
      ctl_b_q <= 8'h00;
      frz_q   <= 1'b0;
    end else if (wr_done) begin
      if (paddr == 12'h0f4) ctl_a_q <= pwdata[7:0];
      if (paddr == 12'h0f0) ctl_b_q <= pwdata[7:0];
      if (paddr == 12'h0f8) frz_q <= pwdata[2];
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  a_irq_gated:
    assert property ($past(ctl_a_q[7:5]) == 3'b000 && ctl_a_q[7:5] == 3'b000 |-> !timer_irq)
    else $error("timer irq high with every source disabled");
  a_pin_route:
    assert property (compare_pin_one_en |-> ctl_b_q[7] || $past(ctl_b_q[7]))
    else $error("pin one owned without its enable bit");
  a_freeze_pins:
    assert property (frz_q && $past(frz_q) |-> !compare_pin_one_en && !compare_pin_two_en)
    else $error("compare pin owned while frozen");
  a_pin_hold:
    assert property (!compare_pin_one_en && $past(!compare_pin_one_en) |-> $stable(compare_pin_one))
    else $error("pin one level moved while not owned");
  a_bus_resp:
    assert property (psel && !penable |=> pready && (pslverr == !mapped))
    else $error("wrong apb response after setup");
  a_ready_idle:
    assert property (pready || !psel |=> !pready)
    else $error("pready not a single access cycle");
  a_reserved_zero:
    assert property (pready && !pwrite && (paddr == 12'h0f8 || paddr == 12'h0f0)
                     |-> prdata[31:8] == 24'h00_0000 && !prdata[0])
    else $error("reserved read bits not zero");
  a_ctrl_readback:
    assert property (pready && !pwrite && paddr == 12'h0f4 |-> (prdata[7:0] & 8'he7) == (ctl_a_q & 8'he7))
    else $error("control a readback differs from last write");
  a_freeze_readback:
    assert property (pready && !pwrite && paddr == 12'h0f8 |-> prdata[2] == frz_q)
    else $error("freeze bit readback differs from last write");
endmodule

bind timer8 timer8_checker u_checker (
  .clock(clock), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .compare_pin_one(compare_pin_one), .compare_pin_one_en(compare_pin_one_en),
  .compare_pin_two_en(compare_pin_two_en), .timer_irq(timer_irq));
